// >>> wsc_pkg.sv
// package: constants for the write strobe control block
package wsc_pkg;
	localparam int          CODE_W          = 6;
	localparam logic [5:0]  CODE_MIN        = 6'h00;
	localparam logic [5:0]  CODE_MAX        = 6'h3F;
	localparam logic [2:0]  TERM_OFF        = 3'h0;
	localparam int          CNT_W           = 6;
	// on/off limits in command clocks, per band and latency set
	localparam logic [5:0]  ON_B0_A         = 6'h00;
	localparam logic [5:0]  ON_B0_B         = 6'h00;
	localparam logic [5:0]  OFF_B0_A        = 6'h0F;
	localparam logic [5:0]  OFF_B0_B        = 6'h0F;
	localparam logic [5:0]  ON_B1_A         = 6'h04;
	localparam logic [5:0]  ON_B1_B         = 6'h0C;
	localparam logic [5:0]  OFF_B1_A        = 6'h18;
	localparam logic [5:0]  OFF_B1_B        = 6'h20;
	localparam logic [5:0]  ON_B2_A         = 6'h08;
	localparam logic [5:0]  ON_B2_B         = 6'h18;
	localparam logic [5:0]  OFF_B2_A        = 6'h24;
	localparam logic [5:0]  OFF_B2_B        = 6'h34;
	localparam logic [1:0]  BAND_266        = 2'h0;
	localparam logic [1:0]  BAND_1066       = 2'h1;
	localparam logic [1:0]  BAND_2133       = 2'h2;
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_PD   = 2'b01,
		CAL_PU   = 2'b11,
		CAL_DONE = 2'b10
	} wsc_cal_e;
endpackage

// >>> wsc_cal.sv
// module: pull-down then pull-up drive strength calibration
`timescale 1ns/1ns
`default_nettype none
module wsc_cal
	import wsc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              start,
	input  wire logic              cmp_low,
	input  wire logic              cmp_high,
	output logic [CODE_W-1:0]      pd_code,
	output logic [CODE_W-1:0]      pu_code,
	output logic                   busy,
	output logic                   done
);
	wsc_cal_e state;

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	// one step per clock; comparator inputs are already synchronised
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= CAL_IDLE;
			pd_code <= CODE_MIN;
			pu_code <= CODE_MIN;
		end else begin
			case (state)
			CAL_IDLE, CAL_DONE: begin
				if (start) begin
					state   <= CAL_PD;
					pd_code <= CODE_MIN;
					pu_code <= CODE_MIN;
				end
			end
			CAL_PD: begin
				if (cmp_low || pd_code == CODE_MAX)
					state <= CAL_PU;
				else
					pd_code <= pd_code + 6'h01;
			end
			CAL_PU: begin
				if (cmp_high || pu_code == CODE_MAX)
					state <= CAL_DONE;
				else
					pu_code <= pu_code + 6'h01;
			end
			default: state <= CAL_IDLE;
			endcase
		end
	end

	assign busy = (state == CAL_PD) || (state == CAL_PU);
	assign done = (state == CAL_DONE);
endmodule // wsc_cal
`default_nettype wire

// >>> wsc_top.sv
// module: device-side write strobe window tracking and termination
`timescale 1ns/1ns
`default_nettype none
module wsc_top
	import wsc_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              CK_IN,
	input  wire logic              CKE,
	input  wire logic              WR_CMD,
	input  wire logic              RD_BUSY,
	input  wire logic              DQS_T,
	input  wire logic              DQS_C,
	input  wire logic              WINDOW_MODE,
	input  wire logic              LAT_SET_B,
	input  wire logic [1:0]        FREQ_BAND,
	input  wire logic [2:0]        TERMINATION_VALUE_FIELD,
	input  wire logic              CAL_START,
	input  wire logic              CMP_LOW,
	input  wire logic              CMP_HIGH,
	output logic                   TERM_EN,
	output logic [2:0]             TERMINATION_RESISTANCE,
	output logic                   STROBE_FAULT,
	output logic                   STROBE_REQUIRED,
	output logic [CODE_W-1:0]      PD_CODE,
	output logic [CODE_W-1:0]      PU_CODE,
	output logic                   CAL_BUSY,
	output logic                   CAL_DONE_O
);
	import wsc_pkg::*;

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	logic [7:0] s1;
	logic [7:0] s2;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1 <= 8'h00;
			s2 <= 8'h00;
		end else begin
			s1 <= {CK_IN, CKE, WR_CMD, RD_BUSY, DQS_T, DQS_C,
				CMP_LOW, CMP_HIGH};
			s2 <= s1;
		end
	end
	logic ck_s, cke_s, wr_s, rd_s, dqt_s, dqc_s, cl_s, ch_s;
	assign {ck_s, cke_s, wr_s, rd_s, dqt_s, dqc_s, cl_s, ch_s} = s2;

	logic ck_d;
	logic wr_d;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ck_d <= 1'b0;
			wr_d <= 1'b0;
		end else begin
			ck_d <= ck_s;
			wr_d <= wr_s;
		end
	end
	// command clock edges count the windows; no ck edge, no count
	logic ck_rise;
	logic wr_rise;
	assign ck_rise = ck_s & ~ck_d;
	assign wr_rise = wr_s & ~wr_d;

	// ------------------------------------------------------------
	// band limits
	// ------------------------------------------------------------
	function automatic logic [5:0] lim(input logic [1:0] band,
		input logic setb, input logic off);
		logic [5:0] r;
		r = 6'h00;
		case (band)
		BAND_266:  r = off ? (setb ? OFF_B0_B : OFF_B0_A)
			: (setb ? ON_B0_B : ON_B0_A);
		BAND_1066: r = off ? (setb ? OFF_B1_B : OFF_B1_A)
			: (setb ? ON_B1_B : ON_B1_A);
		BAND_2133: r = off ? (setb ? OFF_B2_B : OFF_B2_A)
			: (setb ? ON_B2_B : ON_B2_A);
		default:   r = 6'h00;
		endcase
		return r;
	endfunction

	logic [5:0] on_lim;
	logic [5:0] off_lim;
	assign on_lim  = lim(FREQ_BAND, LAT_SET_B, 1'b0);
	assign off_lim = lim(FREQ_BAND, LAT_SET_B, 1'b1);

	// ------------------------------------------------------------
	// window tracking
	// ------------------------------------------------------------
	// counts ck edges since the last write; a new write restarts it
	logic [CNT_W-1:0] since_wr;
	logic             active;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			since_wr <= 6'h00;
			active   <= 1'b0;
		end else if (wr_rise) begin
			since_wr <= 6'h00;
			active   <= 1'b1;
		end else if (ck_rise && active) begin
			if (since_wr >= off_lim)
				active <= 1'b0;
			else
				since_wr <= since_wr + 6'h01;
		end
	end

	logic diff;
	logic exempt;
	logic in_window;
	assign diff = dqt_s ^ dqc_s;
	// reads and turnarounds waive checks; CKE low is don't care
	assign exempt = rd_s | ~cke_s;
	// quarter-clock placement slack is absorbed by edge sampling
	assign in_window = active && since_wr >= on_lim;
	// read scheme: outside bursts DQS_c must stand high
	logic need;
	assign need = WINDOW_MODE ? in_window : 1'b1;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			STROBE_FAULT    <= 1'b0;
			STROBE_REQUIRED <= 1'b0;
		end else begin
			STROBE_REQUIRED <= need & ~exempt;
			if (WINDOW_MODE) begin
				// toggling burst keeps diff true, so it counts
				STROBE_FAULT <= in_window & ~exempt & ~diff;
			end else begin
				STROBE_FAULT <= ~exempt & ~active & ~dqc_s;
			end
		end
	end

	// ------------------------------------------------------------
	// termination
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			TERM_EN                <= 1'b0;
			TERMINATION_RESISTANCE <= TERM_OFF;
		end else begin
			TERM_EN <= active &&
				TERMINATION_VALUE_FIELD != TERM_OFF;
			TERMINATION_RESISTANCE <= TERMINATION_VALUE_FIELD;
		end
	end

	// ------------------------------------------------------------
	// calibration
	// ------------------------------------------------------------
	wsc_cal u_cal (
		.clk      (CLK),
		.rst_n    (RST_N),
		.start    (CAL_START),
		.cmp_low  (cl_s),
		.cmp_high (ch_s),
		.pd_code  (PD_CODE),
		.pu_code  (PU_CODE),
		.busy     (CAL_BUSY),
		.done     (CAL_DONE_O)
	);
endmodule // wsc_top
`default_nettype wire

// >>> wsc_host_model.sv
// partner: host side, command clock, write command and strobe pair
`timescale 1ns/1ns
`default_nettype none
module wsc_host_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic go,
	input  wire logic bad,
	output logic      ck,
	output logic      wr,
	output logic      dqs_t,
	output logic      dqs_c
);
	logic [8:0] left;
	initial begin
		ck = 1'b0;
		#37;
		forever #200 ck = ~ck;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr   <= 1'b0;
			left <= 9'h000;
		end else begin
			wr <= go;
			// 36 command clocks, short of the longest off limit used (52)
			if (go) left <= 9'h120;
			else if (left != 9'h000) left <= left - 9'h001;
		end
	end
	// edges land on ck, well inside the quarter-clock slack
	assign dqs_t = (left != 9'h000) ? ck : 1'b0;
	// bad is the only misbehaviour, asked for by the bench
	assign dqs_c = bad ? 1'b0 : ((left != 9'h000) ? ~ck : 1'b1);
endmodule // wsc_host_model
`default_nettype wire

// >>> wsc_top_props.sv
// checker: port-level properties of the strobe control top
`timescale 1ns/1ns
`default_nettype none
module wsc_top_props
	import wsc_pkg::*;
(
	input wire logic              CLK,
	input wire logic              RST_N,
	input wire logic              WR_CMD,
	input wire logic [2:0]        TERMINATION_VALUE_FIELD,
	input wire logic              CAL_START,
	input wire logic              TERM_EN,
	input wire logic [2:0]        TERMINATION_RESISTANCE,
	input wire logic [CODE_W-1:0] PD_CODE,
	input wire logic [CODE_W-1:0] PU_CODE,
	input wire logic              CAL_BUSY,
	input wire logic              CAL_DONE_O
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_wr_term;
		$rose(WR_CMD) && TERMINATION_VALUE_FIELD != TERM_OFF;
	endsequence
	a_term_on_write: assert property (s_wr_term |-> ##4 TERM_EN)
		else $error("termination missing after write");
	a_term_needs_code: assert property (TERM_EN |-> TERMINATION_RESISTANCE != TERM_OFF)
		else $error("termination with zero field");
	a_pd_steps_up: assert property ($changed(PD_CODE) |->
		PD_CODE == $past(PD_CODE) + 6'h01 || PD_CODE == CODE_MIN)
		else $error("pull-down code jumped");
	a_pu_after_pd: assert property ($changed(PU_CODE) && PU_CODE != CODE_MIN
		|-> $stable(PD_CODE))
		else $error("pull-up moved with pull-down");
	a_done_holds: assert property (CAL_DONE_O && !CAL_START
		|=> $stable(PD_CODE) && $stable(PU_CODE))
		else $error("codes moved after done");
	a_cal_bounded: assert property ($rose(CAL_BUSY) |-> ##[1:160] CAL_DONE_O)
		else $error("calibration did not finish");
endmodule // wsc_top_props
bind wsc_top wsc_top_props i_props (.CLK, .RST_N, .WR_CMD,
	.TERMINATION_VALUE_FIELD, .CAL_START, .TERM_EN,
	.TERMINATION_RESISTANCE, .PD_CODE, .PU_CODE, .CAL_BUSY, .CAL_DONE_O);
`default_nettype wire

// >>> wsc_top_tb.sv
// testbench: strobe control top with host model and comparators
`timescale 1ns/1ns
`default_nettype none
module wsc_top_tb;
	import wsc_pkg::*;
	logic              CLK, RST_N, CKE, RD_BUSY, WINDOW_MODE, LAT_SET_B;
	logic              CAL_START, CMP_LOW, CMP_HIGH, go, bad, CK_IN, WR_CMD;
	logic              DQS_T, DQS_C, TERM_EN, STROBE_FAULT, STROBE_REQUIRED;
	logic              CAL_BUSY, CAL_DONE_O;
	logic [1:0]        FREQ_BAND;
	logic [2:0]        field, TERMINATION_RESISTANCE;
	logic [CODE_W-1:0] PD_CODE, PU_CODE;
	int                num_errors = 0, n_checks = 0, cyc = 0;
	// row: field code, then expected termination enable
	logic [3:0] rows [8] = '{4'h0, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hD, 4'hF};
	wsc_top i_dut (.CLK, .RST_N, .CK_IN, .CKE, .WR_CMD, .RD_BUSY, .DQS_T,
		.DQS_C, .WINDOW_MODE, .LAT_SET_B, .FREQ_BAND,
		.TERMINATION_VALUE_FIELD(field), .CAL_START, .CMP_LOW, .CMP_HIGH,
		.TERM_EN, .TERMINATION_RESISTANCE, .STROBE_FAULT, .STROBE_REQUIRED,
		.PD_CODE, .PU_CODE, .CAL_BUSY, .CAL_DONE_O);
	wsc_host_model i_host (.clk(CLK), .rst_n(RST_N), .go, .bad, .ck(CK_IN),
		.wr(WR_CMD), .dqs_t(DQS_T), .dqs_c(DQS_C));
	task automatic chk(string what, logic [5:0] exp, logic [5:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wait_n(int n);
		repeat (n) @(posedge CLK);
	endtask
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			summarize();
		end
	end
	// resistor stand-ins trip once the code is strong enough
	always @(posedge CLK) begin
		CMP_LOW  <= PD_CODE >= 6'h05;
		CMP_HIGH <= PU_CODE >= 6'h09;
	end
	initial begin
		{RST_N, RD_BUSY, LAT_SET_B, CAL_START, go, bad} = '0;
		{CKE, WINDOW_MODE, FREQ_BAND, field} = 7'h60;
		wait_n(3);
		RST_N <= 1'b1;
		foreach (rows[i]) begin
			field     <= rows[i][3:1];
			FREQ_BAND <= {1'b0, rows[i][2]};
			LAT_SET_B <= rows[i][1];
			go        <= 1'b1;
			wait_n(1);
			go <= 1'b0;
			wait_n(12);
			chk("term_en", {5'h00, rows[i][0]}, {5'h00, TERM_EN});
			chk("term_res", {3'h0, rows[i][3:1]}, {3'h0, TERMINATION_RESISTANCE});
		end
		// ----------------------------------------
		// strobe misuse, exemptions, calibration
		// ----------------------------------------
		WINDOW_MODE <= 1'b0;
		bad         <= 1'b1;
		wait_n(320);
		chk("fault", 6'h01, {5'h00, STROBE_FAULT});
		RD_BUSY <= 1'b1;
		wait_n(6);
		chk("fault_rd", 6'h00, {5'h00, STROBE_FAULT});
		RD_BUSY <= 1'b0;
		CKE     <= 1'b0;
		wait_n(6);
		chk("fault_cke", 6'h00, {5'h00, STROBE_FAULT});
		chk("req_cke", 6'h00, {5'h00, STROBE_REQUIRED});
		CKE <= 1'b1;
		bad <= 1'b0;
		wait_n(6);
		chk("fault_ok", 6'h00, {5'h00, STROBE_FAULT});
		chk("req_rd_mode", 6'h01, {5'h00, STROBE_REQUIRED});
		// window scheme, top band, set B: on 24, off 52 command clocks
		WINDOW_MODE <= 1'b1;
		FREQ_BAND   <= BAND_2133;
		LAT_SET_B   <= 1'b1;
		go          <= 1'b1;
		wait_n(1);
		go <= 1'b0;
		wait_n(100);
		chk("req_early", 6'h00, {5'h00, STROBE_REQUIRED});
		wait_n(220);
		chk("req_win", 6'h01, {5'h00, STROBE_REQUIRED});
		chk("fault_win", 6'h00, {5'h00, STROBE_FAULT});
		wait_n(200);
		chk("req_off", 6'h00, {5'h00, STROBE_REQUIRED});
		CAL_START <= 1'b1;
		wait_n(1);
		CAL_START <= 1'b0;
		wait_n(200);
		chk("cal_done", 6'h01, {5'h00, CAL_DONE_O});
		chk("pd", 6'h01, {5'h00, PD_CODE >= 6'h05 && PD_CODE <= 6'h09});
		chk("pu", 6'h01, {5'h00, PU_CODE >= 6'h09 && PU_CODE <= 6'h0D});
		summarize();
	end
endmodule // wsc_top_tb
`default_nettype wire
